/* inc/wdg_pkg.sv */
package wdg_pkg;

  // ----------------------------------------------------------------
  // Register map and bus answers
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_KICK = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned TSEL_W = 3;
  localparam int unsigned CTRL_TSEL_LSB = 0;
  localparam int unsigned CTRL_ON_BIT = 3;
  localparam int unsigned CTRL_UNLOCK_BIT = 4;
  localparam int unsigned STAT_LEVEL_LSB = 0;
  localparam int unsigned STAT_RUN_BIT = 2;
  localparam int unsigned STAT_WINDOW_BIT = 3;
  localparam int unsigned STAT_EXPIRED_BIT = 4;
  localparam logic [2:0] TSEL_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam int unsigned OSC_BASE_CYCLES = 16384;

  typedef enum logic [1:0] {LVL0, LVL1, LVL2} wdg_level_e;
  typedef enum logic [1:0] {INIT_S1, INIT_S2, INIT_LATCH, INIT_DONE} wdg_init_e;

  typedef struct packed {
    logic unlock;
    logic on;
    logic [TSEL_W-1:0] tsel;
  } wdg_ctrl_s;

endpackage

/* hdl/wdg_config_guard.sv */
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns

module wdg_config_guard #(
  parameter int unsigned OSC_BASE = wdg_pkg::OSC_BASE_CYCLES,
  parameter int unsigned CNT_W = 22
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic WDOG_OSC,
  input wire logic COMPAT_FUSE,
  input wire logic ALWAYS_ON_FUSE,
  output logic WDOG_RESET,
  output logic WDOG_RUNNING,
  input wire logic [wdg_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [wdg_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (OSC_BASE < 2 || CNT_W > 31 || (longint'(OSC_BASE) << 7) > (64'd1 << CNT_W))
  begin : g_bad_param
    $error("OSC_BASE shifted by seven does not fit the counter width");
  end

  function automatic wdg_pkg::wdg_ctrl_s ctrl_of(input logic [31:0] d);
    ctrl_of.unlock = d[wdg_pkg::CTRL_UNLOCK_BIT];
    ctrl_of.on = d[wdg_pkg::CTRL_ON_BIT];
    ctrl_of.tsel = d[wdg_pkg::CTRL_TSEL_LSB +: wdg_pkg::TSEL_W];
  endfunction

  function automatic logic [CNT_W-1:0] limit_of(input logic [wdg_pkg::TSEL_W-1:0] sel);
    limit_of = CNT_W'(OSC_BASE) << sel;
  endfunction

  logic aw_have_q, w_have_q, bvalid_q, arready_q, rvalid_q;
  // Ready flags are their own flops so that the bus outputs come straight from registers.
  logic awready_q, wready_q;
  logic [wdg_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q, rdata_d;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q, rresp_d;
  logic wr_go;
  logic ctrl_wr, kick_wr;
  wdg_pkg::wdg_ctrl_s wc;
  logic [1:0] fuse_s1_q, fuse_s2_q;
  wdg_pkg::wdg_init_e init_q;
  wdg_pkg::wdg_level_e level_q;
  logic on_q;
  logic [wdg_pkg::TSEL_W-1:0] tsel_q;
  logic [2:0] unlock_cnt_q;
  logic win_open;
  logic osc_s1_q, osc_s2_q, osc_prev_q, osc_tick;
  logic [CNT_W-1:0] cnt_q;
  logic expire, wdog_reset_q, expired_q;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= wdg_pkg::RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else
    begin
      if (S_AXI_AWVALID && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_have_q)
      begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= (aw_addr_q == wdg_pkg::ADDR_CTRL || aw_addr_q == wdg_pkg::ADDR_STAT ||
                    aw_addr_q == wdg_pkg::ADDR_KICK) ? wdg_pkg::RESP_OKAY : wdg_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && S_AXI_BREADY)
      begin
        bvalid_q <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Writes before the fuses are latched are answered but have no effect.
  assign ctrl_wr = wr_go && aw_addr_q == wdg_pkg::ADDR_CTRL && w_strb_q[0] &&
                   init_q == wdg_pkg::INIT_DONE;
  assign kick_wr = wr_go && aw_addr_q == wdg_pkg::ADDR_KICK;
  assign wc = ctrl_of(w_data_q);

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = '0;
    rresp_d = wdg_pkg::RESP_OKAY;
    case (S_AXI_ARADDR)
      wdg_pkg::ADDR_CTRL:
      begin
        rdata_d[wdg_pkg::CTRL_UNLOCK_BIT] = win_open;
        rdata_d[wdg_pkg::CTRL_ON_BIT] = on_q || level_q == wdg_pkg::LVL2;
        rdata_d[wdg_pkg::CTRL_TSEL_LSB +: wdg_pkg::TSEL_W] = tsel_q;
      end
      wdg_pkg::ADDR_STAT:
      begin
        rdata_d[wdg_pkg::STAT_LEVEL_LSB +: 2] = (level_q == wdg_pkg::LVL2) ? 2'h2 :
                                                (level_q == wdg_pkg::LVL1) ? 2'h1 : 2'h0;
        rdata_d[wdg_pkg::STAT_RUN_BIT] = on_q;
        rdata_d[wdg_pkg::STAT_WINDOW_BIT] = win_open;
        rdata_d[wdg_pkg::STAT_EXPIRED_BIT] = expired_q;
      end
      wdg_pkg::ADDR_KICK: rdata_d = '0;
      default: rresp_d = wdg_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= wdg_pkg::RESP_OKAY;
    end
    else if (S_AXI_ARVALID && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
    else if (rvalid_q && S_AXI_RREADY)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  // ----------------------------------------------------------------
  // Fuse capture
  // ----------------------------------------------------------------
  // Fuses are static, so they are synchronised and latched once after reset release.
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      fuse_s1_q <= 2'h0;
      fuse_s2_q <= 2'h0;
    end
    else
    begin
      fuse_s1_q <= {ALWAYS_ON_FUSE, COMPAT_FUSE};
      fuse_s2_q <= fuse_s1_q;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      init_q <= wdg_pkg::INIT_S1;
      level_q <= wdg_pkg::LVL1;
    end
    else
    begin
      case (init_q)
        wdg_pkg::INIT_S1: init_q <= wdg_pkg::INIT_S2;
        wdg_pkg::INIT_S2: init_q <= wdg_pkg::INIT_LATCH;
        wdg_pkg::INIT_LATCH:
        begin
          init_q <= wdg_pkg::INIT_DONE;
          level_q <= fuse_s2_q[1] ? wdg_pkg::LVL2 :
                     fuse_s2_q[0] ? wdg_pkg::LVL0 : wdg_pkg::LVL1;
        end
        wdg_pkg::INIT_DONE: init_q <= wdg_pkg::INIT_DONE;
        default: init_q <= wdg_pkg::INIT_S1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Unlock window
  // ----------------------------------------------------------------
  assign win_open = unlock_cnt_q != 3'h0;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
      unlock_cnt_q <= 3'h0;
    else if (ctrl_wr && wc.unlock && wc.on)
      unlock_cnt_q <= wdg_pkg::UNLOCK_CYCLES;
    else if (win_open)
      unlock_cnt_q <= unlock_cnt_q - 3'h1;
  end

  // ----------------------------------------------------------------
  // Enable and time-out select
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      on_q <= 1'b0;
      tsel_q <= wdg_pkg::TSEL_RESET;
    end
    else if (init_q == wdg_pkg::INIT_LATCH)
      on_q <= fuse_s2_q[1];
    else if (ctrl_wr)
    begin
      case (level_q)
        wdg_pkg::LVL2:
        begin
          on_q <= 1'b1;
          if (win_open && !wc.unlock)
            tsel_q <= wc.tsel;
        end
        wdg_pkg::LVL1:
        begin
          if (win_open && !wc.unlock)
          begin
            on_q <= wc.on;
            tsel_q <= wc.tsel;
          end
          else if (wc.on)
            on_q <= 1'b1;
        end
        wdg_pkg::LVL0:
        begin
          tsel_q <= wc.tsel;
          if (wc.on)
            on_q <= 1'b1;
          else if (win_open)
            on_q <= 1'b0;
        end
        default: on_q <= on_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Time-out counter
  // ----------------------------------------------------------------
  // The oscillator is sampled, never used as a clock, so it must stay well below CLK_SYS.
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end
    else
    begin
      osc_s1_q <= WDOG_OSC;
      osc_s2_q <= osc_s1_q;
      osc_prev_q <= osc_s2_q;
    end
  end

  assign osc_tick = osc_s2_q && !osc_prev_q;
  assign expire = on_q && osc_tick && !kick_wr && cnt_q >= limit_of(tsel_q) - CNT_W'(1);

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
      cnt_q <= '0;
    else if (!on_q || kick_wr || expire)
      cnt_q <= '0;
    else if (osc_tick)
      cnt_q <= cnt_q + CNT_W'(1);
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      wdog_reset_q <= 1'b0;
      expired_q <= 1'b0;
    end
    else
    begin
      wdog_reset_q <= expire;
      expired_q <= expired_q || expire;
    end
  end

  assign WDOG_RESET = wdog_reset_q;
  assign WDOG_RUNNING = on_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  level2_always_on_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (init_q == wdg_pkg::INIT_DONE && level_q == wdg_pkg::LVL2) |-> on_q)
    else $error("Level 2 watchdog is not running");

  level2_no_off_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (level_q == wdg_pkg::LVL2 && on_q) |=> on_q)
    else $error("Level 2 watchdog was disabled");

  window_close_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (ctrl_wr && wc.unlock && wc.on) ##1 !(ctrl_wr && wc.unlock && wc.on) [*4] |=> !win_open)
    else $error("Unlock window did not close after four cycles");

  lvl1_off_guard_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (level_q == wdg_pkg::LVL1 && $fell(on_q)) |-> $past(win_open) && !$past(wc.unlock))
    else $error("Level 1 disable outside the unlock window");

  lvl0_off_guard_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (level_q == wdg_pkg::LVL0 && $fell(on_q)) |-> $past(win_open))
    else $error("Level 0 disable without unlock");

  tsel_guard_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (level_q != wdg_pkg::LVL0 && !$stable(tsel_q)) |-> $past(win_open) && $past(ctrl_wr))
    else $error("Time-out changed outside the unlock window");

  lvl0_tsel_free_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (level_q == wdg_pkg::LVL0 && ctrl_wr) |=> tsel_q == $past(wc.tsel))
    else $error("Level 0 time-out write not applied");

  lvl1_enable_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (level_q == wdg_pkg::LVL1 && ctrl_wr && wc.on) |=> on_q)
    else $error("Level 1 enable write not applied");

  window_apply_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (level_q == wdg_pkg::LVL1 && ctrl_wr && win_open && !wc.unlock)
    |=> on_q == $past(wc.on) && tsel_q == $past(wc.tsel))
    else $error("Level 1 window write not applied");

  expire_cause_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    WDOG_RESET |-> $past(on_q) && $past(cnt_q) == limit_of($past(tsel_q)) - CNT_W'(1))
    else $error("Watchdog reset without a full time-out");

endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ns

module tb_top;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  localparam int unsigned OSC_B = 4;
  localparam int CEIL = 60000;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic wdog_osc = 1'b0;
  logic compat_fuse = 1'b0;
  logic always_on_fuse = 1'b0;
  logic wdog_reset, wdog_running;
  logic [wdg_pkg::ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, last_bresp, last_rresp;
  int num_errors = 0, comparisons = 0, cycles = 0, osc_n = 0;

  wdg_config_guard #(.OSC_BASE(OSC_B)) dut_u (
    .CLK_SYS(clk_sys), .RESETN(resetn), .WDOG_OSC(wdog_osc),
    .COMPAT_FUSE(compat_fuse), .ALWAYS_ON_FUSE(always_on_fuse),
    .WDOG_RESET(wdog_reset), .WDOG_RUNNING(wdog_running),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  always #50 clk_sys = ~clk_sys;
  // The 510 half period puts every fifth oscillator edge on a system clock edge, the first at 2550.
  always #510 wdog_osc = ~wdog_osc;
  always @(posedge wdog_osc) osc_n++;

  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic b_d;
    b_d = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b0;
    while (!b_d)
    begin
      @(posedge clk_sys);
      last_bresp = bresp;
      if (bvalid && bready) b_d = 1'b1;
      if (!awvalid && !wvalid && !b_d) bready <= 1'b1;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    logic r_d;
    r_d = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b0;
    while (!r_d)
    begin
      @(posedge clk_sys);
      d = rdata;
      last_rresp = rresp;
      if (rvalid && rready) r_d = 1'b1;
      if (arvalid && arready) rready <= 1'b1;
      if (arvalid && arready) arvalid <= 1'b0;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %0d expected %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp, "read data");
  endtask

  function automatic logic [31:0] ctl(input logic u, input logic o, input logic [2:0] t);
    return {27'h000_0000, u, o, t};
  endfunction

  task automatic boot(input logic cf, input logic af);
    resetn <= 1'b0;
    compat_fuse <= cf;
    always_on_fuse <= af;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == CEIL)
    begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence, one reset each for levels 0 and 1, two for level 2 (compat fuse low and high)
  // ----------------------------------------------------------------
  initial
  begin
    boot(1'b1, 1'b0);
    rdchk(wdg_pkg::ADDR_STAT, 32'h0000_0000);
    rdchk(wdg_pkg::ADDR_CTRL, 32'h0000_0000);
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 3'h5));
    chk(last_bresp, wdg_pkg::RESP_OKAY, "bresp");
    rdchk(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 3'h5));
    chk(last_rresp, wdg_pkg::RESP_OKAY, "rresp");
    wr(wdg_pkg::ADDR_STAT, 32'h0000_001F);
    rdchk(wdg_pkg::ADDR_STAT, 32'h0000_0000);
    wstrb <= 4'hE;
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 3'h2));
    wstrb <= 4'hF;
    rdchk(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 3'h5));
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b1, 3'h5));
    chk(wdog_running, 1'b1, "running");
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 3'h5));
    chk(wdog_running, 1'b1, "running");
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 3'h5));
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 3'h5));
    chk(wdog_running, 1'b0, "running");
    wr(4'hC, 32'h0000_0000);
    chk(last_bresp, wdg_pkg::RESP_SLVERR, "bresp");
    rdchk(4'hC, 32'h0000_0000);
    chk(last_rresp, wdg_pkg::RESP_SLVERR, "rresp");
    rdchk(wdg_pkg::ADDR_KICK, 32'h0000_0000);
    for (int s = 0; s < 8; s++)
    begin
      wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b1, 3'(s)));
      wr(wdg_pkg::ADDR_KICK, 32'h0000_0000);
      osc_n = 0;
      while (wdog_reset !== 1'b1) @(posedge clk_sys);
      chk_rng(osc_n, (OSC_B << s) - 1, (OSC_B << s) + 1, "time-out");
    end
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b1, 3'h0));
    wr(wdg_pkg::ADDR_KICK, 32'h0000_0000);
    osc_n = 0;
    while (osc_n < 2) @(posedge clk_sys);
    wr(wdg_pkg::ADDR_KICK, 32'h0000_0000);
    osc_n = 0;
    while (wdog_reset !== 1'b1) @(posedge clk_sys);
    chk_rng(osc_n, OSC_B - 1, OSC_B + 1, "kick restart");
    rdchk(wdg_pkg::ADDR_STAT, 32'h0000_0014);

    boot(1'b0, 1'b0);
    rdchk(wdg_pkg::ADDR_STAT, 32'h0000_0001);
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 3'h3));
    rdchk(wdg_pkg::ADDR_CTRL, 32'h0000_0000);
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b1, 3'h0));
    chk(wdog_running, 1'b1, "running");
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 3'h0));
    chk(wdog_running, 1'b1, "running");
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 3'h0));
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b1, 3'h3));
    rdchk(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b1, 3'h3));
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 3'h3));
    rdchk(wdg_pkg::ADDR_STAT, 32'h0000_000D);
    repeat (4) @(posedge clk_sys);
    rdchk(wdg_pkg::ADDR_STAT, 32'h0000_0005);
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 3'h6));
    rdchk(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b1, 3'h3));
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 3'h3));
    wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 3'h3));
    chk(wdog_running, 1'b0, "running");

    for (int cf = 0; cf < 2; cf++)
    begin
      boot(1'(cf), 1'b1);
      rdchk(wdg_pkg::ADDR_STAT, 32'h0000_0006);
      rdchk(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b1, 3'h0));
      wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 3'h4));
      rdchk(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b1, 3'h0));
      wr(wdg_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 3'h0));
      wr(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 3'h6));
      rdchk(wdg_pkg::ADDR_CTRL, ctl(1'b0, 1'b1, 3'h6));
      chk(wdog_running, 1'b1, "running");
    end
    conclude();
  end
endmodule
